//--- shared/sbpp_pkg.sv
// Purpose: Constants and types for the bus priority poll block
// Assumes: One bus transfer cycle spans a whole number of clocks
// Notes: Summary of operation follows
// Summary of operation
// - Watch and drive all 23 priority lines
// - Per-line mask selects only higher-ranked agents
// - Masked lines plus top line form lost-poll
// - Data return asserts top line one cycle early, own line on the console variant
// - Memory transfer asserts own line one cycle early
// - Only the own line, or the top line for data return, is ever driven
// - Higher transfer next cycle suppresses memory transfer
// - Poll only on microengine command
// - Console variant never drives the top line
// - Tag outputs and address recognition notify microengine
// - Interrupt poll only on microengine request
package sbpp_pkg;
  // Bus geometry
  localparam int PRIO_LINES = 23;
  localparam int TOP_LINE = 0;
  localparam int GROUP_A_LAST = 11;
  localparam int LEVEL_W = 5;
  localparam int ADDR_W = 6;
  localparam int SYNC_STAGES = 3;
  // Timing: 150 ns bus cycle on a 50 ns clock
  localparam int CLK_PERIOD_NS = 50;
  localparam int BUS_CYCLE_NS = 150;
  localparam int CYCLE_CLKS = BUS_CYCLE_NS / CLK_PERIOD_NS;
  localparam int PHASE_W = 2;
  localparam logic [PHASE_W-1:0] PHASE_FIRST = 2'h0;
  localparam logic [PHASE_W-1:0] PHASE_LAST = PHASE_W'(CYCLE_CLKS - 1);
  // Reset values
  localparam logic [PRIO_LINES-1:0] DRIVE_RST = 23'h000000;
  localparam logic [PRIO_LINES-1:0] OE_RST = 23'h7fffff;
  // Poll sequencer states
  typedef enum logic [1:0] {IDLE, POLL, XFER} sbpp_state_t;
endpackage : sbpp_pkg

//--- logic/sbpp_sync.sv
// Purpose: Three-stage input synchroniser with agreement filter
// Assumes: Inputs may change at any time relative to sys_clk
// Notes: Output updates only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module sbpp_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Raw and filtered data
  input wire logic [WIDTH-1:0] rawIn,
  output logic [WIDTH-1:0] syncOut
);
  // Whole state of the synchroniser
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] q;
  } sbpp_sync_t;

  sbpp_sync_t syncReg;
  sbpp_sync_t syncNext;

  // Width must be usable
  if (WIDTH < 1) begin : g_bad_width
    $error("sbpp_sync: WIDTH must be at least one");
  end

  // Shift chain; s1 feeds only s2 to avoid metastable fan-out
  always_comb begin
    syncNext = syncReg;
    syncNext.s1 = rawIn;
    syncNext.s2 = syncReg.s1;
    syncNext.s3 = syncReg.s2;
    // Bitwise agreement filter rejects single-clock glitches
    syncNext.q = (syncReg.s2 & syncReg.s3) | (syncReg.q & (syncReg.s2 | syncReg.s3));
  end

  // State register
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      syncReg <= '0;
    end else begin
      syncReg <= syncNext;
    end
  end

  assign syncOut = syncReg.q;
endmodule : sbpp_sync
`default_nettype wire

//--- logic/sbpp_poll.sv
// Purpose: Distributed priority polling and transfer control for the backplane
// Assumes: Microengine requests are one-clock pulses on sys_clk
// Notes: Bus cycle boundary is a local phase counter of three clocks
`timescale 1ns/1ps
`default_nettype none
module sbpp_poll (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Priority lines, open drain
  input wire logic [sbpp_pkg::PRIO_LINES-1:0] prioIn,
  output logic [sbpp_pkg::PRIO_LINES-1:0] prioOut,
  output logic [sbpp_pkg::PRIO_LINES-1:0] prioOe_b,
  // Jumper configuration
  input wire logic [sbpp_pkg::PRIO_LINES-1:0] higherCfg,
  input wire logic [sbpp_pkg::LEVEL_W-1:0] ownLevelCfg,
  input wire logic consoleCfg,
  input wire logic [sbpp_pkg::ADDR_W-1:0] boardAddrCfg,
  // Incoming bus tags and destination
  input wire logic busXferTag,
  input wire logic busMemTag,
  input wire logic busCpuBit,
  input wire logic [sbpp_pkg::ADDR_W-1:0] busDest,
  // Microengine requests
  input wire logic memoryPollRequest,
  input wire logic dataReturnTransfer,
  input wire logic intPollRequest,
  // Status and transfer control
  output logic xferGo,
  output logic xferIsDrt,
  output logic xferTag,
  output logic memTag,
  output logic pollBusy,
  output logic lostPollCombined,
  output logic intPollOut,
  output logic addrHit
);
  localparam int SYNC_W = 2 * sbpp_pkg::PRIO_LINES + sbpp_pkg::LEVEL_W
                          + 2 * sbpp_pkg::ADDR_W + 4;

  // Whole state of the poll block
  typedef struct packed {
    logic [sbpp_pkg::PHASE_W-1:0] phase;
    sbpp_pkg::sbpp_state_t st;
    logic memPend;
    logic drtPend;
    logic intPend;
    logic goDrt;
    logic [sbpp_pkg::PRIO_LINES-1:0] drive;
    logic [sbpp_pkg::PRIO_LINES-1:0] oeB;
    logic go;
    logic xferTag;
    logic memTag;
    logic intPoll;
    logic lost;
    logic addrHit;
    logic busy;
  } sbpp_regs_t;

  sbpp_regs_t stateReg;
  sbpp_regs_t stateNext;

  // Filtered pin views
  logic [sbpp_pkg::PRIO_LINES-1:0] prioSync;
  logic [sbpp_pkg::PRIO_LINES-1:0] higherSync;
  logic [sbpp_pkg::LEVEL_W-1:0] ownLevel;
  logic console;
  logic [sbpp_pkg::ADDR_W-1:0] boardAddr;
  logic [sbpp_pkg::ADDR_W-1:0] destSync;
  logic xferTagIn;
  logic memTagIn;
  logic cpuBitIn;
  // Derived conditions
  logic [sbpp_pkg::PRIO_LINES-1:0] ownHot;
  logic [sbpp_pkg::PRIO_LINES-1:0] watched;
  logic lostPollGroupA;
  logic lostPollGroupB;
  logic topSeen;
  logic lostNow;
  logic addrMatch;
  logic lastPh;
  logic useTop;

  // One-hot of a priority level; levels outside 1..22 drive nothing
  function automatic logic [sbpp_pkg::PRIO_LINES-1:0] lineOf(
    input logic [sbpp_pkg::LEVEL_W-1:0] lvl);
    logic [sbpp_pkg::PRIO_LINES-1:0] hot;
    hot = '0;
    for (int i = 1; i < sbpp_pkg::PRIO_LINES; i++) begin
      if (lvl == sbpp_pkg::LEVEL_W'(i)) begin
        hot[i] = 1'b1;
      end
    end
    return hot;
  endfunction : lineOf

  // Bus pins and straps pass the three-stage filter; microengine requests bypass it
  sbpp_sync #(.WIDTH(SYNC_W)) u_sync (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .rawIn({prioIn, higherCfg, ownLevelCfg, consoleCfg, boardAddrCfg,
            busDest, busXferTag, busMemTag, busCpuBit}),
    .syncOut({prioSync, higherSync, ownLevel, console, boardAddr,
              destSync, xferTagIn, memTagIn, cpuBitIn})
  );

  // Lost-poll detection; own line always excluded from the watch set
  always_comb begin
    ownHot = lineOf(ownLevel);
    watched = prioSync & higherSync & ~ownHot;
    lostPollGroupA = |watched[sbpp_pkg::GROUP_A_LAST:1];
    lostPollGroupB = |watched[sbpp_pkg::PRIO_LINES-1:sbpp_pkg::GROUP_A_LAST+1];
    topSeen = prioSync[sbpp_pkg::TOP_LINE];
    lostNow = lostPollGroupA | lostPollGroupB | topSeen;
    addrMatch = xferTagIn & ~memTagIn & ~cpuBitIn & (destSync == boardAddr);
    lastPh = (stateReg.phase == sbpp_pkg::PHASE_LAST);
    useTop = stateReg.drtPend & ~console;
  end

  // Next-state logic: one decision per bus transfer cycle
  always_comb begin
    stateNext = stateReg;
    stateNext.go = 1'b0;
    stateNext.addrHit = 1'b0;
    stateNext.lost = lostNow;
    // Phase counter marks bus cycle boundaries
    if (lastPh) begin
      stateNext.phase = sbpp_pkg::PHASE_FIRST;
    end else begin
      stateNext.phase = stateReg.phase + 2'h1;
    end
    case (stateReg.st)
      sbpp_pkg::IDLE: begin
        // Top line bypasses ordering but still yields to another top driver
        if (lastPh && (stateReg.drtPend || stateReg.memPend)) begin
          if (useTop ? !topSeen : !lostNow) begin
            stateNext.goDrt = stateReg.drtPend;
            if (useTop) begin
              stateNext.drive = '0;
              stateNext.drive[sbpp_pkg::TOP_LINE] = 1'b1;
            end else begin
              stateNext.drive = ownHot;
            end
            stateNext.oeB = ~stateNext.drive;
            stateNext.st = sbpp_pkg::POLL;
          end
        end
      end
      sbpp_pkg::POLL: begin
        // Lines stand for the whole cycle before the transfer
        if (lastPh) begin
          stateNext.drive = sbpp_pkg::DRIVE_RST;
          stateNext.oeB = sbpp_pkg::OE_RST;
          stateNext.st = sbpp_pkg::XFER;
        end
      end
      sbpp_pkg::XFER: begin
        // Filtered lines now show the poll cycle; a higher winner cancels
        if (stateReg.phase == sbpp_pkg::PHASE_FIRST) begin
          if ((stateReg.goDrt && !console) || !lostNow) begin
            stateNext.go = 1'b1;
            stateNext.xferTag = 1'b1;
            stateNext.memTag = ~stateReg.goDrt;
            if (stateReg.goDrt) begin
              stateNext.drtPend = 1'b0;
            end else begin
              stateNext.memPend = 1'b0;
            end
          end
        end
        if (lastPh) begin
          stateNext.xferTag = 1'b0;
          stateNext.memTag = 1'b0;
          stateNext.st = sbpp_pkg::IDLE;
        end
      end
      default: begin
        stateNext.st = sbpp_pkg::IDLE;
      end
    endcase
    // Busy kept as its own flop so the status pin has no decode glitches
    stateNext.busy = (stateNext.st != sbpp_pkg::IDLE);
    // Interrupt poll stands for one bus cycle after a request
    if (lastPh) begin
      stateNext.intPoll = stateReg.intPend;
      stateNext.intPend = 1'b0;
    end
    // Address recognition sampled late in the cycle
    if (lastPh && addrMatch) begin
      stateNext.addrHit = 1'b1;
    end
    // Requests last, so a set in a clearing cycle wins
    if (memoryPollRequest) begin
      stateNext.memPend = 1'b1;
    end
    if (dataReturnTransfer) begin
      stateNext.drtPend = 1'b1;
    end
    if (intPollRequest) begin
      stateNext.intPend = 1'b1;
    end
  end

  // State register
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      stateReg <= '0;
      stateReg.st <= sbpp_pkg::IDLE;
      stateReg.oeB <= sbpp_pkg::OE_RST;
    end else begin
      stateReg <= stateNext;
    end
  end

  // Outputs straight from flops
  assign prioOut = stateReg.drive;
  assign prioOe_b = stateReg.oeB;
  assign xferGo = stateReg.go;
  assign xferIsDrt = stateReg.goDrt;
  assign xferTag = stateReg.xferTag;
  assign memTag = stateReg.memTag;
  assign pollBusy = stateReg.busy;
  assign lostPollCombined = stateReg.lost;
  assign intPollOut = stateReg.intPoll;
  assign addrHit = stateReg.addrHit;

  // Checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_enter_poll;
    stateReg.st == sbpp_pkg::IDLE ##1 stateReg.st == sbpp_pkg::POLL;
  endsequence
  sequence s_poll_cycle;
    (stateReg.st == sbpp_pkg::POLL)[*3] ##1 stateReg.st == sbpp_pkg::XFER;
  endsequence

  a_poll_needs_cmd: assert property (
    s_enter_poll |-> $past(stateReg.memPend || stateReg.drtPend))
    else $error("poll started without a request");
  a_poll_one_cycle: assert property (
    $rose(stateReg.st == sbpp_pkg::POLL) |-> s_poll_cycle)
    else $error("poll did not last one bus cycle");
  a_drive_onehot: assert property (
    $onehot0(stateReg.drive) && stateReg.oeB == ~stateReg.drive)
    else $error("more than one priority line driven");
  a_mem_own_line: assert property (
    stateReg.st == sbpp_pkg::POLL && !stateReg.goDrt |-> stateReg.drive == ownHot)
    else $error("memory poll not on own line");
  a_drt_top_line: assert property (
    stateReg.st == sbpp_pkg::POLL && stateReg.goDrt && !console
    |-> stateReg.drive[sbpp_pkg::TOP_LINE])
    else $error("data return did not use top line");
  a_console_no_top: assert property (
    console && $stable(console) |-> !stateReg.drive[sbpp_pkg::TOP_LINE])
    else $error("console variant drove top line");
  a_lost_cancels: assert property (
    stateReg.st == sbpp_pkg::XFER && stateReg.phase == sbpp_pkg::PHASE_FIRST
    && !stateReg.goDrt && lostNow |=> !stateReg.go ##1 !stateReg.go)
    else $error("memory transfer went despite lost poll");
  a_lost_no_start: assert property (
    stateReg.st == sbpp_pkg::IDLE && lastPh && lostNow && !stateReg.drtPend
    |=> stateReg.st == sbpp_pkg::IDLE)
    else $error("poll started while lost");
  a_int_on_req: assert property (
    $rose(stateReg.intPoll) |-> $past(stateReg.intPend) && $past(lastPh))
    else $error("interrupt poll without request");
  a_addr_notify: assert property (
    stateReg.addrHit |-> $past(addrMatch) && $past(lastPh))
    else $error("address hit without a match");
endmodule : sbpp_poll
`default_nettype wire

//--- verification/sbpp_agents.sv
// Purpose: Other bus agents sharing the open-drain priority lines
// Assumes: Pull-ups hold a released line at its deasserted level, read here as 0
// Notes: A single agent of adjustable level stands in for the far side
`timescale 1ns/1ps
`default_nettype none
module sbpp_agents (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Our drivers on the lines
  input wire logic [22:0] prioOut,
  input wire logic [22:0] prioOe_b,
  // Agent control from the bench
  input wire logic [4:0] agentLevel,
  input wire logic agentReq,
  // Resolved line levels
  output logic [22:0] prioIn
);
  logic [22:0] ourDrive; // Lines we pull active
  logic [22:0] upMask; // Lines ranked above the agent
  logic heldOff_reg; // Higher line seen last cycle
  assign ourDrive = prioOut & ~prioOe_b;
  assign upMask = (23'h1 << agentLevel) - 23'h1;
  // Wired-OR of all drivers
  assign prioIn = ourDrive | ((agentReq && !heldOff_reg) ? (23'h1 << agentLevel) : 23'h0);
  // Agent backs off after seeing a higher line
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      heldOff_reg <= 1'b0;
    end else begin
      heldOff_reg <= |(ourDrive & upMask);
    end
  end
endmodule : sbpp_agents
`default_nettype wire

//--- verification/system_bus_priority_poll_test.sv
// Purpose: Self-checking bench for the priority poll block
// Assumes: Requests are one-clock pulses, bus cycle of three clocks
// Notes: Expected drive patterns queue up at request time
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((e) !== (g)) begin fail_count++; $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module system_bus_priority_poll_test;
  logic sys_clk = 1'b0, rst_b = 1'b0; // Clock and reset
  logic [22:0] prioIn, prioOut, prioOe_b, higherCfg = 23'h0; // Lines and straps
  logic [4:0] ownLevelCfg = 5'h01, agentLevel = 5'h00;
  logic [5:0] boardAddrCfg = 6'h00, busDest = 6'h00;
  logic consoleCfg = 1'b0, busXferTag = 1'b0, busMemTag = 1'b0, busCpuBit = 1'b0;
  logic memoryPollRequest = 1'b0, dataReturnTransfer = 1'b0, intPollRequest = 1'b0;
  logic agentReq = 1'b0;
  logic xferGo, xferIsDrt, xferTag, memTag, pollBusy, lostPollCombined, intPollOut, addrHit;
  logic [22:0] expQ[$]; // Reference model of pending drives
  int fail_count = 0, tests_run = 0, n;
  bit ok;
  always #25 sys_clk = ~sys_clk;
  sbpp_poll sbpp_poll_i (.sys_clk(sys_clk), .rst_b(rst_b), .prioIn(prioIn), .prioOut(prioOut),
    .prioOe_b(prioOe_b), .higherCfg(higherCfg), .ownLevelCfg(ownLevelCfg),
    .consoleCfg(consoleCfg), .boardAddrCfg(boardAddrCfg), .busXferTag(busXferTag),
    .busMemTag(busMemTag), .busCpuBit(busCpuBit), .busDest(busDest),
    .memoryPollRequest(memoryPollRequest), .dataReturnTransfer(dataReturnTransfer),
    .intPollRequest(intPollRequest), .xferGo(xferGo), .xferIsDrt(xferIsDrt),
    .xferTag(xferTag), .memTag(memTag), .pollBusy(pollBusy),
    .lostPollCombined(lostPollCombined), .intPollOut(intPollOut), .addrHit(addrHit));
  sbpp_agents sbpp_agents_i (.sys_clk(sys_clk), .rst_b(rst_b), .prioOut(prioOut),
    .prioOe_b(prioOe_b), .agentLevel(agentLevel), .agentReq(agentReq), .prioIn(prioIn));
  // Step to just after the next rising edge
  task automatic tick(input int k = 1);
    repeat (k) begin
      @(posedge sys_clk);
      #1;
    end
  endtask : tick
  // Condition picker for bounded waits
  function automatic logic cond(input int sel);
    case (sel)
      0: cond = (~prioOe_b !== 23'h0);
      1: cond = xferGo;
      2: cond = intPollOut;
      default: cond = addrHit;
    endcase
  endfunction : cond
  // Bounded wait; running out is a mismatch
  task automatic waitFor(input int sel, input int lim);
    ok = 1'b0;
    for (int i = 0; i < lim && !ok; i++) begin
      tick();
      ok = (cond(sel) === 1'b1);
    end
    if (!ok) begin
      fail_count++;
      $display("[FAIL] wait %0d exp 1 got 0", sel);
      end_of_test();
    end
  endtask : waitFor
  // Issue a poll and record the line it must drive
  task automatic req(input int data_return_transfer);
    expQ.push_back((data_return_transfer && !consoleCfg) ? 23'h1 : (23'h1 << ownLevelCfg));
    if (data_return_transfer) dataReturnTransfer = 1'b1;
    else memoryPollRequest = 1'b1;
    tick();
    dataReturnTransfer = 1'b0;
    memoryPollRequest = 1'b0;
  endtask : req
  // Follow the poll through drive and grant
  task automatic finish(input int data_return_transfer);
    logic [22:0] e;
    e = expQ.pop_front();
    waitFor(0, 90);
    `CHK("prioOut", e, prioOut)
    `CHK("prioOe_b", ~e, prioOe_b)
    waitFor(1, 12);
    `CHK("memTag", data_return_transfer == 0, memTag)
    `CHK("xferIsDrt", data_return_transfer != 0, xferIsDrt)
    `CHK("xferTag", 1'b1, xferTag)
    `CHK("pollBusy", 1'b1, pollBusy)
    tick(6);
    `CHK("xferTag end", 1'b0, xferTag)
    `CHK("pollBusy end", 1'b0, pollBusy)
  endtask : finish
  // Count cycles in which a condition holds
  task automatic count(input int sel, input int k);
    n = 0;
    repeat (k) begin
      tick();
      if (cond(sel) === 1'b1) n++;
    end
  endtask : count
  // Verdict and end of run
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test
  // Main sequence
  initial begin
    void'($urandom(85082));
    tick(12);
    `CHK("prioOe_b rst", 23'h7fffff, prioOe_b)
    `CHK("prioOut rst", 23'h0, prioOut)
    rst_b = 1'b1;
    tick(6);
    count(0, 30);
    `CHK("idle drives", 0, n)
    $display("test idle done");
    // Random levels and higher masks, both variants
    for (int i = 0; i < 4; i++) begin
      ownLevelCfg = 5'(1 + $urandom % 22);
      higherCfg = 23'($urandom) & ((23'h1 << ownLevelCfg) - 23'h1);
      consoleCfg = i[0];
      tick(6);
      req(0);
      finish(0);
      req(1);
      finish(1);
    end
    $display("test levels done");
    // Lost poll to a watched higher agent, then the agent moves to a lower unwatched line and the poll runs
    ownLevelCfg = 5'h05;
    higherCfg = 23'h8;
    consoleCfg = 1'b0;
    agentLevel = 5'h03;
    agentReq = 1'b1;
    tick(6);
    req(0);
    count(0, 30);
    `CHK("drive while lost", 0, n)
    `CHK("lostPollCombined", 1'b1, lostPollCombined)
    agentLevel = 5'h09;
    finish(0);
    agentLevel = 5'h00;
    tick(8);
    `CHK("top line lost", 1'b1, lostPollCombined)
    agentReq = 1'b0;
    tick(8);
    $display("test lost done");
    // Interrupt poll for one bus cycle
    intPollRequest = 1'b1;
    tick();
    intPollRequest = 1'b0;
    waitFor(2, 5);
    count(2, 8);
    `CHK("intPollOut len", 2, n)
    $display("test interrupt done");
    // Higher agent arrives after our decision: poll runs, transfer cancelled
    intPollRequest = 1'b1;
    tick();
    intPollRequest = 1'b0;
    waitFor(2, 5);
    agentLevel = 5'h03;
    agentReq = 1'b1;
    req(0);
    count(0, 5);
    `CHK("cancel poll len", 3, n)
    count(1, 7);
    `CHK("cancel xferGo", 0, n)
    agentReq = 1'b0;
    finish(0);
    $display("test cancel done");
    // Address recognition, match then miss
    boardAddrCfg = 6'($urandom);
    busDest = boardAddrCfg;
    busXferTag = 1'b1;
    tick(6);
    waitFor(3, 12);
    busDest = boardAddrCfg ^ 6'h01;
    tick(6);
    count(3, 12);
    `CHK("addrHit miss", 0, n)
    busDest = boardAddrCfg;
    busMemTag = 1'b1;
    tick(6);
    count(3, 12);
    `CHK("addrHit mem", 0, n)
    busMemTag = 1'b0;
    busCpuBit = 1'b1;
    tick(6);
    count(3, 12);
    `CHK("addrHit cpu", 0, n)
    busCpuBit = 1'b0;
    busXferTag = 1'b0;
    $display("test address done");
    end_of_test();
  end
endmodule : system_bus_priority_poll_test
`default_nettype wire
